// >>> verilog/bcmcw_core.sv
// Behaviour
// R1: retry on timeout or format error when enabled
// R2: also retry on status set if flagged-enabled
// R3: bus select bit one means bus A
// R4: loopback message never drives either bus
// R5: loopback feeds encoded word into selected decoder
// R6: loopback result reported in loop-fail flag
// R7: 16-bit time base stores looped word
// R8: 32-bit time base stores time tag high
// R9: mask mode treats bit as mask
// R10: mask zero and bit4 set flags status
// R11: mask one ignores received bit4
// R12: expected mode bit holds expected bit4
// R13: expected mode mismatch flags, match ignored
// R14: control bits latched at message start
//
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module bcmcw_core #(
  parameter int MAX_RETRY = bcmcw_pkg::MAX_RETRY_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [bcmcw_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire bcmcw_pkg::bcmcw_rsp_t rsp,
  input wire logic [31:0] time_tag,
  output bcmcw_pkg::bcmcw_enc_t enc
);
  typedef enum logic [1:0] {S_IDLE, S_SEND, S_WAIT, S_EVAL} bcmcw_state_t;

  if (MAX_RETRY < 1 || MAX_RETRY > 7)
  begin : g_max_retry_range
    $error("MAX_RETRY must be 1 to 7");
  end

  // broadcast-received contribution to the status-set decision
  function automatic logic bcr_status_set(input logic mode, input logic mbit, input logic rbit);
    bcr_status_set = mode ? (~mbit & rbit) : (mbit ^ rbit);
  endfunction : bcr_status_set

  logic [31:0] cfg_ff, nxt_cfg;
  logic [31:0] ctrl_ff, nxt_ctrl;
  logic [15:0] cmd_ff, nxt_cmd;
  logic [15:0] loopw_ff, nxt_loopw;
  logic [31:0] prdata_ff, nxt_prdata;
  bcmcw_state_t state_ff, nxt_state;
  bcmcw_pkg::bcmcw_ctl_t ctl_ff, nxt_ctl;
  logic [2:0] retries_ff, nxt_retries;
  logic done_ff, nxt_done;
  logic loop_fail_ff, nxt_loop_fail;
  logic sset_ff, nxt_sset;
  logic retried_ff, nxt_retried;
  logic timeout_ff, nxt_timeout;
  logic fmt_ff, nxt_fmt;
  logic [15:0] rxw_ff, nxt_rxw;
  bcmcw_pkg::bcmcw_enc_t enc_ff, nxt_enc;

  logic acc, wr, mapped, start;
  logic sset_now, err_now, retry_now, fail_now;

  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign pready = 1'b1;
  assign mapped = paddr inside {bcmcw_pkg::OFS_CFG, bcmcw_pkg::OFS_CTRL, bcmcw_pkg::OFS_CMD,
    bcmcw_pkg::OFS_START, bcmcw_pkg::OFS_STAT, bcmcw_pkg::OFS_LOOPW};
  assign pslverr = acc & ~mapped;
  assign start = wr & (paddr == bcmcw_pkg::OFS_START) & pwdata[0] & (state_ff == S_IDLE);
  assign enc = enc_ff;
  assign prdata = prdata_ff;

  // read data is registered at the setup edge, so it stands for the whole access cycle
  always_comb
  begin
    nxt_prdata = 32'h0000_0000;
    case (paddr)
      bcmcw_pkg::OFS_CFG: nxt_prdata = cfg_ff;
      bcmcw_pkg::OFS_CTRL: nxt_prdata = ctrl_ff;
      bcmcw_pkg::OFS_CMD: nxt_prdata = {16'h0000, cmd_ff};
      bcmcw_pkg::OFS_STAT:
      begin
        nxt_prdata[bcmcw_pkg::ST_BUSY] = (state_ff != S_IDLE);
        nxt_prdata[bcmcw_pkg::ST_DONE] = done_ff;
        nxt_prdata[bcmcw_pkg::ST_LOOP_FAIL] = loop_fail_ff; // R6
        nxt_prdata[bcmcw_pkg::ST_STATUS_SET] = sset_ff;
        nxt_prdata[bcmcw_pkg::ST_RETRIED] = retried_ff;
        nxt_prdata[bcmcw_pkg::ST_BUS_A] = ctl_ff.bus_a;
      end
      bcmcw_pkg::OFS_LOOPW: nxt_prdata = {16'h0000, loopw_ff};
      default: nxt_prdata = 32'h0000_0000;
    endcase
  end

  // decision terms from the captured response
  always_comb
  begin
    sset_now = bcr_status_set(cfg_ff[bcmcw_pkg::CFG_MASK_MODE], ctl_ff.bcr_mask,
      rxw_ff[bcmcw_pkg::SW_BCR]); // R9 R10 R11 R12 R13
    err_now = timeout_ff | fmt_ff;
    retry_now = ctl_ff.retry_req & cfg_ff[bcmcw_pkg::CFG_RETRY_GLOBAL] & ~ctl_ff.loopback
      & (retries_ff != 3'(MAX_RETRY))
      & (err_now | (cfg_ff[bcmcw_pkg::CFG_RETRY_FLAGGED] & sset_now)); // R1 R2
    fail_now = err_now | (rxw_ff != cmd_ff);
  end

  always_comb
  begin
    nxt_cfg = cfg_ff;
    nxt_ctrl = ctrl_ff;
    nxt_cmd = cmd_ff;
    if (wr && paddr == bcmcw_pkg::OFS_CFG)
    begin
      nxt_cfg = pwdata;
    end
    if (wr && paddr == bcmcw_pkg::OFS_CTRL)
    begin
      nxt_ctrl = pwdata;
    end
    if (wr && paddr == bcmcw_pkg::OFS_CMD)
    begin
      nxt_cmd = pwdata[15:0];
    end
  end

  always_comb
  begin
    nxt_state = state_ff;
    nxt_ctl = ctl_ff;
    nxt_retries = retries_ff;
    nxt_done = done_ff;
    nxt_loop_fail = loop_fail_ff;
    nxt_sset = sset_ff;
    nxt_retried = retried_ff;
    nxt_timeout = timeout_ff;
    nxt_fmt = fmt_ff;
    nxt_rxw = rxw_ff;
    nxt_loopw = loopw_ff;
    nxt_enc = enc_ff;
    nxt_enc.valid = 1'b0;
    case (state_ff)
      S_IDLE:
      begin
        nxt_enc = '0;
        if (start)
        begin
          nxt_ctl.retry_req = ctrl_ff[bcmcw_pkg::CW_RETRY_REQ]; // R14
          nxt_ctl.bus_a = ctrl_ff[bcmcw_pkg::CW_BUS_A];
          nxt_ctl.loopback = ctrl_ff[bcmcw_pkg::CW_LOOPBACK];
          nxt_ctl.bcr_mask = ctrl_ff[bcmcw_pkg::CW_BCR_MASK];
          nxt_retries = 3'h0;
          nxt_done = 1'b0;
          nxt_retried = 1'b0;
          nxt_state = S_SEND;
        end
      end
      S_SEND:
      begin
        nxt_enc.valid = 1'b1;
        nxt_enc.word = cmd_ff;
        nxt_enc.bus_a_en = ~ctl_ff.loopback & ctl_ff.bus_a; // R3 R4
        nxt_enc.bus_b_en = ~ctl_ff.loopback & ~ctl_ff.bus_a; // R3 R4
        nxt_enc.loop_en = ctl_ff.loopback; // R5
        nxt_enc.loop_bus_a = ctl_ff.bus_a; // R5
        nxt_state = S_WAIT;
      end
      S_WAIT:
      begin
        if (rsp.valid || rsp.timeout || rsp.format_err)
        begin
          nxt_timeout = rsp.timeout;
          nxt_fmt = rsp.format_err;
          nxt_rxw = rsp.word;
          nxt_state = S_EVAL;
        end
      end
      S_EVAL:
      begin
        nxt_enc = '0;
        if (retry_now)
        begin
          nxt_retries = retries_ff + 3'h1;
          nxt_retried = 1'b1;
          nxt_state = S_SEND;
        end
        else
        begin
          nxt_sset = sset_now & ~err_now;
          nxt_loop_fail = ctl_ff.loopback & fail_now; // R6
          if (ctl_ff.loopback)
          begin
            nxt_loopw = cfg_ff[bcmcw_pkg::CFG_TB32]
              ? time_tag[bcmcw_pkg::LOOPW_HI:bcmcw_pkg::LOOPW_LO] // R8
              : rxw_ff; // R7
          end
          nxt_done = 1'b1;
          nxt_state = S_IDLE;
        end
      end
      default: nxt_state = S_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_ff <= bcmcw_pkg::CFG_RST;
      ctrl_ff <= bcmcw_pkg::CTRL_RST;
      cmd_ff <= bcmcw_pkg::CMD_RST;
      loopw_ff <= bcmcw_pkg::LOOPW_RST;
      prdata_ff <= bcmcw_pkg::RDATA_RST;
      state_ff <= S_IDLE;
      ctl_ff <= '0;
      retries_ff <= 3'h0;
      done_ff <= 1'b0;
      loop_fail_ff <= 1'b0;
      sset_ff <= 1'b0;
      retried_ff <= 1'b0;
      timeout_ff <= 1'b0;
      fmt_ff <= 1'b0;
      rxw_ff <= 16'h0000;
      enc_ff <= '0;
    end
    else
    begin
      cfg_ff <= nxt_cfg;
      ctrl_ff <= nxt_ctrl;
      cmd_ff <= nxt_cmd;
      loopw_ff <= nxt_loopw;
      prdata_ff <= nxt_prdata;
      state_ff <= nxt_state;
      ctl_ff <= nxt_ctl;
      retries_ff <= nxt_retries;
      done_ff <= nxt_done;
      loop_fail_ff <= nxt_loop_fail;
      sset_ff <= nxt_sset;
      retried_ff <= nxt_retried;
      timeout_ff <= nxt_timeout;
      fmt_ff <= nxt_fmt;
      rxw_ff <= nxt_rxw;
      enc_ff <= nxt_enc;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_retry_err;
    (state_ff == S_EVAL) && err_now && ctl_ff.retry_req && !ctl_ff.loopback
      && cfg_ff[bcmcw_pkg::CFG_RETRY_GLOBAL] && retries_ff == 3'h0 |=> state_ff == S_SEND
      ##1 enc.valid;
  endproperty
  a_retry_err: assert property (p_retry_err) else $error("no retry after error"); // R1

  property p_retry_sset;
    (state_ff == S_EVAL) && !err_now && sset_now && retries_ff == 3'h0
      && !ctl_ff.loopback && !(ctl_ff.retry_req && cfg_ff[bcmcw_pkg::CFG_RETRY_GLOBAL]
      && cfg_ff[bcmcw_pkg::CFG_RETRY_FLAGGED]) |=> state_ff == S_IDLE && !retried_ff;
  endproperty
  a_retry_sset: assert property (p_retry_sset) else $error("status retry without enables"); // R2

  property p_bus_sel;
    enc.valid && !enc.loop_en |-> enc.bus_a_en == ctl_ff.bus_a && enc.bus_b_en == !ctl_ff.bus_a;
  endproperty
  a_bus_sel: assert property (p_bus_sel) else $error("wrong bus selected"); // R3

  property p_loop_quiet;
    ctl_ff.loopback && state_ff != S_IDLE |-> !enc.bus_a_en && !enc.bus_b_en;
  endproperty
  a_loop_quiet: assert property (p_loop_quiet) else $error("loopback drove a bus"); // R4

  property p_loop_route;
    (state_ff == S_SEND) && ctl_ff.loopback |=> enc.loop_en && enc.loop_bus_a == ctl_ff.bus_a
      && enc.word == cmd_ff;
  endproperty
  a_loop_route: assert property (p_loop_route) else $error("loopback not routed"); // R5

  property p_loop_fail;
    (state_ff == S_EVAL) && ctl_ff.loopback |=> loop_fail_ff == $past(fail_now) && done_ff;
  endproperty
  a_loop_fail: assert property (p_loop_fail) else $error("loop fail flag wrong"); // R6

  property p_loopw;
    (state_ff == S_EVAL) && ctl_ff.loopback |=> loopw_ff == ($past(cfg_ff[bcmcw_pkg::CFG_TB32])
      ? $past(time_tag[bcmcw_pkg::LOOPW_HI:bcmcw_pkg::LOOPW_LO]) : $past(rxw_ff));
  endproperty
  a_loopw: assert property (p_loopw) else $error("loopback word wrong"); // R7 R8

  property p_sset;
    (state_ff == S_EVAL) |-> sset_now == (cfg_ff[bcmcw_pkg::CFG_MASK_MODE]
      ? (!ctl_ff.bcr_mask && rxw_ff[bcmcw_pkg::SW_BCR])
      : (ctl_ff.bcr_mask != rxw_ff[bcmcw_pkg::SW_BCR]));
  endproperty
  a_sset: assert property (p_sset) else $error("status set decision wrong"); // R9 R10 R11 R12 R13

  property p_ctl_hold;
    state_ff != S_IDLE && nxt_state != S_IDLE |=> $stable(ctl_ff);
  endproperty
  a_ctl_hold: assert property (p_ctl_hold) else $error("control bits changed mid message"); // R14

  c_retry: cover property (state_ff == S_EVAL && retry_now);
  c_loop_pass: cover property (state_ff == S_EVAL && ctl_ff.loopback && !fail_now);
  c_bus_b: cover property (enc.valid && enc.bus_b_en);
  c_sset: cover property (state_ff == S_EVAL && sset_now);
endmodule : bcmcw_core

// >>> verilog/bcmcw_pkg.sv
package bcmcw_pkg;
  localparam int ADDR_W = 8;
  // register byte offsets
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_CMD = 8'h08;
  localparam logic [7:0] OFS_START = 8'h0C;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam logic [7:0] OFS_LOOPW = 8'h14;
  // controller configuration fields
  localparam int CFG_RETRY_GLOBAL = 12;
  localparam int CFG_RETRY_FLAGGED = 8;
  localparam int CFG_TB32 = 1;
  localparam int CFG_MASK_MODE = 0;
  // control word fields
  localparam int CW_RETRY_REQ = 8;
  localparam int CW_BUS_A = 7;
  localparam int CW_LOOPBACK = 6;
  localparam int CW_BCR_MASK = 5;
  // received status word field
  localparam int SW_BCR = 4;
  // status register fields
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_LOOP_FAIL = 8;
  localparam int ST_STATUS_SET = 3;
  localparam int ST_RETRIED = 4;
  localparam int ST_BUS_A = 5;
  localparam int LOOPW_HI = 31;
  localparam int LOOPW_LO = 16;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] CMD_RST = 16'h0000;
  localparam logic [15:0] LOOPW_RST = 16'h0000;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;
  localparam int MAX_RETRY_DEF = 1;

  typedef struct packed {
    logic valid;
    logic timeout;
    logic format_err;
    logic [15:0] word;
  } bcmcw_rsp_t;

  typedef struct packed {
    logic valid;
    logic bus_a_en;
    logic bus_b_en;
    logic loop_en;
    logic loop_bus_a;
    logic [15:0] word;
  } bcmcw_enc_t;

  typedef struct packed {
    logic retry_req;
    logic bus_a;
    logic loopback;
    logic bcr_mask;
  } bcmcw_ctl_t;
endpackage : bcmcw_pkg

// >>> tb/bcmcw_rt_model.sv
`timescale 1ns/1ps
module bcmcw_rt_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire bcmcw_pkg::bcmcw_enc_t enc,
  input wire logic [1:0] fault,
  input wire logic [15:0] status,
  input wire logic [3:0] dly,
  output bcmcw_pkg::bcmcw_rsp_t rsp
);
  logic pend;
  logic live;
  logic [3:0] cnt;
  logic [15:0] lw;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rsp <= '0;
      pend <= 1'b0;
      live <= 1'b0;
      cnt <= 4'h0;
      lw <= 16'h0000;
    end
    else
    begin
      rsp.valid <= 1'b0;
      rsp.timeout <= 1'b0;
      rsp.format_err <= 1'b0;
      // released decoder output toggles so stale data is never trusted
      rsp.word <= ~rsp.word;
      if (enc.valid)
      begin
        pend <= 1'b1;
        cnt <= dly;
        // an idle bus gets no reply; loopback echoes the encoded word
        live <= enc.bus_a_en | enc.bus_b_en | enc.loop_en;
        lw <= enc.loop_en ? enc.word : status;
      end
      else if (pend && cnt != 4'h0)
        cnt <= cnt - 4'h1;
      else if (pend)
      begin
        pend <= 1'b0;
        rsp.timeout <= !live || fault == 2'd1;
        rsp.format_err <= live && fault == 2'd2;
        rsp.valid <= live && fault == 2'd0;
        rsp.word <= lw;
      end
    end
  end
endmodule : bcmcw_rt_model

// >>> tb/bc_message_control_word_tb.sv
`timescale 1ns/1ps
module bc_message_control_word_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, time_tag, rd, seed, cfg, ctl, cmd, s;
  bcmcw_pkg::bcmcw_rsp_t rsp;
  bcmcw_pkg::bcmcw_enc_t enc;
  logic [1:0] fault, f;
  logic [15:0] status, st;
  logic [3:0] dly;
  logic [8:0] ex;
  int n_errors, check_count, n_send;
  bcmcw_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rsp(rsp), .time_tag(time_tag), .enc(enc));
  bcmcw_rt_model rt (.pclk(pclk), .presetn(presetn), .enc(enc), .fault(fault),
    .status(status), .dly(dly), .rsp(rsp));
  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  // expected status bits 8..0: loop fail, spare x2, bus a, retried, status set, spare, done, busy
  function logic [8:0] exp_stat(input logic [31:0] c, input logic [31:0] t,
    input logic [1:0] fl, input logic s4);
    logic lp, er, ss, rr;
    lp = t[6];
    er = fl != 2'd0;
    ss = !er && (c[0] ? (!t[5] && s4) : (t[5] != s4));
    rr = !lp && t[8] && c[12] && (er || (c[8] && ss));
    return {lp && er, 2'b00, t[7], rr, ss, 1'b0, 1'b1, 1'b0};
  endfunction : exp_stat
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task results();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results
  always @(posedge pclk)
    if (enc.valid === 1'b1)
    begin
      n_send++;
      chk({enc.bus_a_en, enc.bus_b_en, enc.loop_en, enc.loop_bus_a & ctl[6], enc.word},
        {ctl[7] & ~ctl[6], ~ctl[7] & ~ctl[6], ctl[6], ctl[7] & ctl[6], cmd[15:0]});
    end
  initial
  begin
    pclk = 0;
    forever #20 pclk = ~pclk;
  end
  initial
  begin
    repeat (50000) @(posedge pclk);
    n_errors++;
    results();
  end
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, time_tag, fault, status, dly} = '0;
    seed = 32'h0000_002A;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, bcmcw_pkg::OFS_STAT, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 8'h40, 32'hFFFF_FFFF);
    chk({31'h0, perr}, 32'h1);
    for (int i = 0; i < 40; i++)
    begin
      cfg = xs() & 32'h0000_1103;
      ctl = xs() & 32'h0000_01E0;
      cmd = xs() & 32'h0000_FFFF;
      s = xs();
      f = (s[1:0] == 2'd3) ? 2'd0 : s[1:0];
      st = s[31:16];
      if (i == 0)
      begin
        cfg = 32'h2;
        ctl = 32'h40;
        f = 2'd1;
      end
      if (i == 1)
      begin
        cfg = 32'h1100;
        ctl = 32'h100;
        f = 2'd0;
        st[4] = 1'b1;
      end
      fault <= f;
      status <= st;
      dly <= s[5:2];
      time_tag <= xs();
      apb(1'b1, bcmcw_pkg::OFS_CFG, cfg);
      apb(1'b1, bcmcw_pkg::OFS_CTRL, ctl);
      apb(1'b1, bcmcw_pkg::OFS_CMD, cmd);
      n_send = 0;
      apb(1'b1, bcmcw_pkg::OFS_START, 32'h1);
      // control word changes mid-message must not reach this message
      apb(1'b1, bcmcw_pkg::OFS_CTRL, ~ctl);
      do
        apb(1'b0, bcmcw_pkg::OFS_STAT, 32'h0);
      while (rd[1] !== 1'b1);
      // in loopback the decoder hands back the command word itself
      ex = exp_stat(cfg, ctl, f, ctl[6] ? cmd[4] : st[4]);
      chk(rd, {23'h0, ex});
      chk(n_send, 1 + ex[4]);
      if (ctl[6] && (cfg[1] || f == 2'd0))
      begin
        apb(1'b0, bcmcw_pkg::OFS_LOOPW, 32'h0);
        chk(rd, cfg[1] ? {16'h0, time_tag[31:16]} : cmd);
      end
    end
    results();
  end
endmodule : bc_message_control_word_tb
